// *** sbl_ctrl.sv ***
// Host controller driving an asynchronous 64K x 16 static memory with
// two byte lanes, plus low-voltage data-retention entry and exit.
// Assumes the data bus wire is resolved outside from dq_o and dq_oe, and
// that the supply logic lowers Vcc only while retain_active is high.
`timescale 1ns/100ps

// Behaviour
// - Write starts with both low; first rise ends
// - Data held stable across write-ending rising edge
// - Write enable stays high through every read
// - Address valid before chip select falls
// - Deselect no later than retention start
// - Wait one read cycle after retention exit
module sbl_ctrl
  import sbl_pkg::*;
(
  input wire logic clk_sys,                // System clock, 20 MHz
  input wire logic rst,                    // Synchronous reset, high
  input wire logic req_valid,              // Access request present
  input wire sbl_req_t req,                // Access request contents
  output logic req_ready,                  // Request taken when high
  output logic rsp_valid,                  // Access finished, one cycle
  output logic [DATA_W-1:0] rsp_rdata,     // Read data, lanes masked
  input wire logic retain_req,             // Ask for data retention
  output logic retain_active,              // Memory may go to low Vcc
  output sbl_pins_t pins,                  // Strobes and address
  output logic [DATA_W-1:0] dq_o,          // Data bus drive value
  output logic dq_oe,                      // Data bus drive enable
  input wire logic [DATA_W-1:0] dq_i       // Data bus sampled value
);

  sbl_state_t state_ff;
  sbl_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  sbl_req_t cur_ff;
  sbl_req_t nxt_cur;
  sbl_pins_t pins_ff;
  sbl_pins_t nxt_pins;
  logic [DATA_W-1:0] dq_o_ff;
  logic [DATA_W-1:0] nxt_dq_o;
  logic dq_oe_ff;
  logic nxt_dq_oe;
  logic req_ready_ff;
  logic nxt_req_ready;
  logic rsp_valid_ff;
  logic nxt_rsp_valid;
  logic [DATA_W-1:0] rsp_rdata_ff;
  logic [DATA_W-1:0] nxt_rsp_rdata;
  logic retain_active_ff;
  logic nxt_retain_active;
  logic [DATA_W-1:0] dq_meta_ff;
  logic [DATA_W-1:0] dq_sync_ff;
  logic retain_meta_ff;
  logic retain_sync_ff;
  logic [DATA_W-1:0] lane_mask;

  // Pin inputs pass two flops before any logic looks at them
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dq_meta_ff <= '0;
      dq_sync_ff <= '0;
      retain_meta_ff <= 1'b0;
      retain_sync_ff <= 1'b0;
    end
    else
    begin
      dq_meta_ff <= dq_i;
      dq_sync_ff <= dq_meta_ff;
      retain_meta_ff <= retain_req;
      retain_sync_ff <= retain_meta_ff;
    end
  end

  // Byte lanes that the current access owns
  assign lane_mask = {{8{cur_ff.lanes[1]}}, {8{cur_ff.lanes[0]}}};

  // Sequencer: every pin value is decided here and registered below
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cur = cur_ff;
    nxt_pins = pins_ff;
    nxt_dq_o = dq_o_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_rdata = rsp_rdata_ff;
    nxt_retain_active = retain_active_ff;
    case (state_ff)
      ST_IDLE:
      begin
        // Deselected here, so the memory sits in power-down
        nxt_pins = PINS_IDLE;
        nxt_dq_oe = 1'b0;
        if (req_valid)
        begin
          nxt_cur = req;
          // Address goes out while chip select is still high
          nxt_pins.addr = req.addr;
          if (req.write)
          begin
            nxt_state = ST_WR_SETUP;
            nxt_cnt = SA_CYC;
            nxt_dq_o = req.wdata;
            nxt_dq_oe = 1'b1;
          end
          else
          begin
            nxt_state = ST_RD_SETUP;
            nxt_cnt = 4'h1;
          end
        end
        else if (retain_sync_ff)
        begin
          // Already deselected; the register stage adds the delay
          nxt_state = ST_RET_ENTER;
          nxt_cnt = CDR_CYC;
        end
      end
      ST_RD_SETUP:
      begin
        // Select after a full cycle of stable address
        nxt_state = ST_RD_ACCESS;
        nxt_cnt = 4'(AA_CYC + SYNC_CYC);
        nxt_pins.chip_select_n = 1'b0;
        nxt_pins.upper_lane_select_n = ~cur_ff.lanes[1];
        nxt_pins.lower_lane_select_n = ~cur_ff.lanes[0];
        nxt_pins.output_enable_n = 1'b0;
        nxt_pins.write_enable_n = 1'b1;
      end
      ST_RD_ACCESS:
      begin
        // Write enable is never touched while reading
        nxt_pins.write_enable_n = 1'b1;
        if (cnt_ff > 4'h1)
        begin
          nxt_cnt = cnt_ff - 4'h1;
        end
        else
        begin
          // Unselected lanes are masked off, so they read back as zero
          nxt_rsp_rdata = dq_sync_ff & lane_mask;
          nxt_pins = PINS_IDLE;
          nxt_pins.addr = cur_ff.addr;
          nxt_state = ST_RD_RELEASE;
          nxt_cnt = HZ_CYC;
        end
      end
      ST_RD_RELEASE:
      begin
        // Let the memory stop driving before any write may drive
        if (cnt_ff > 4'h1)
        begin
          nxt_cnt = cnt_ff - 4'h1;
        end
        else
        begin
          nxt_rsp_valid = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_WR_SETUP:
      begin
        // Select and lanes go low once address setup has passed
        nxt_pins.chip_select_n = 1'b0;
        nxt_pins.upper_lane_select_n = ~cur_ff.lanes[1];
        nxt_pins.lower_lane_select_n = ~cur_ff.lanes[0];
        nxt_pins.output_enable_n = 1'b1;
        if (cnt_ff > 4'h1)
        begin
          nxt_cnt = cnt_ff - 4'h1;
        end
        else
        begin
          // Overlap of both strobes low opens the write
          nxt_pins.write_enable_n = 1'b0;
          nxt_state = ST_WR_PULSE;
          nxt_cnt = PWE_CYC;
        end
      end
      ST_WR_PULSE:
      begin
        if (cnt_ff > 4'h1)
        begin
          nxt_cnt = cnt_ff - 4'h1;
        end
        else
        begin
          // Write enable rises first and ends the write alone
          nxt_pins.write_enable_n = 1'b1;
          nxt_state = ST_WR_HOLD;
          nxt_cnt = HD_CYC;
        end
      end
      ST_WR_HOLD:
      begin
        // Data and address stay put past the ending edge
        nxt_dq_oe = 1'b1;
        if (cnt_ff > 4'h1)
        begin
          nxt_cnt = cnt_ff - 4'h1;
        end
        else
        begin
          // Chip select rises only after write enable, never together
          nxt_pins = PINS_IDLE;
          nxt_pins.addr = cur_ff.addr;
          nxt_dq_oe = 1'b0;
          nxt_rsp_valid = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_RET_ENTER:
      begin
        // Chip select has been high since idle
        if (cnt_ff > 4'h1)
        begin
          nxt_cnt = cnt_ff - 4'h1;
        end
        else
        begin
          nxt_retain_active = 1'b1;
          nxt_state = ST_RET_HOLD;
        end
      end
      ST_RET_HOLD:
      begin
        nxt_pins = PINS_IDLE;
        if (!retain_sync_ff)
        begin
          nxt_retain_active = 1'b0;
          nxt_state = ST_RET_RECOVER;
          nxt_cnt = RC_CYC;
        end
      end
      ST_RET_RECOVER:
      begin
        // No access until a full read cycle has passed
        if (cnt_ff > 4'h1)
        begin
          nxt_cnt = cnt_ff - 4'h1;
        end
        else
        begin
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_pins = PINS_IDLE;
        nxt_dq_oe = 1'b0;
        nxt_retain_active = 1'b0;
      end
    endcase
    // Ready only in idle, and only while retention is not asked for
    nxt_req_ready = (nxt_state == ST_IDLE) && !retain_sync_ff;
    if ((state_ff == ST_IDLE) && req_valid && !req_ready_ff)
    begin
      // Not taken: stay idle and deselected, or go to retention entry if asked
      nxt_state = state_ff;
      nxt_cur = cur_ff;
      nxt_pins = PINS_IDLE;
      nxt_dq_oe = 1'b0;
      nxt_req_ready = !retain_sync_ff;
      if (retain_sync_ff)
      begin
        nxt_state = ST_RET_ENTER;
        nxt_cnt = CDR_CYC;
      end
    end
  end

  // Register stage; every output comes from here
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      cur_ff <= '0;
      pins_ff <= PINS_IDLE;
      dq_o_ff <= '0;
      dq_oe_ff <= 1'b0;
      req_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= '0;
      retain_active_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cur_ff <= nxt_cur;
      pins_ff <= nxt_pins;
      dq_o_ff <= nxt_dq_o;
      dq_oe_ff <= nxt_dq_oe;
      req_ready_ff <= nxt_req_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_rdata_ff <= nxt_rsp_rdata;
      retain_active_ff <= nxt_retain_active;
    end
  end

  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign retain_active = retain_active_ff;
  assign pins = pins_ff;
  assign dq_o = dq_o_ff;
  assign dq_oe = dq_oe_ff;

endmodule

// *** sbl_pkg.sv ***
// Package for the host-side byte-lane static memory controller.
// Assumes a 20 MHz system clock and the fastest memory speed grade.
package sbl_pkg;

  // Clock period of clk_sys
  localparam int CLK_PERIOD_NS = 50;

  // Memory timing figures in nanoseconds
  localparam int T_RC_NS = 70;   // read_cycle_period, least
  localparam int T_AA_NS = 70;   // address to data valid, most
  localparam int T_SA_NS = 25;   // address setup to write start, least
  localparam int T_PWE_NS = 60;  // write-enable pulse width, least
  localparam int T_HD_NS = 10;   // data hold from write end, least
  localparam int T_CDR_NS = 0;   // deselect_to_retention_delay, least
  localparam int T_HZ_NS = 40;   // output enable high to high Z, most

  // Least times round up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] RC_CYC = 4'(cyc_up(T_RC_NS));
  localparam logic [3:0] AA_CYC = 4'(cyc_up(T_AA_NS));
  localparam logic [3:0] SA_CYC = 4'(cyc_up(T_SA_NS));
  localparam logic [3:0] PWE_CYC = 4'(cyc_up(T_PWE_NS));
  localparam logic [3:0] HD_CYC = 4'(cyc_up(T_HD_NS));
  localparam logic [3:0] CDR_CYC = 4'(cyc_up(T_CDR_NS));
  localparam logic [3:0] HZ_CYC = 4'(cyc_up(T_HZ_NS));
  // Extra cycles spent in the data input synchroniser
  localparam logic [3:0] SYNC_CYC = 4'h2;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // Idle value of the strobe pins: all deasserted high
  localparam logic STROBE_IDLE = 1'b1;

  // One access asked for by the user side
  typedef struct packed {
    logic write;                // 1 write, 0 read
    logic [1:0] lanes;          // [1] upper byte, [0] lower byte, active high
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sbl_req_t;

  // Strobe and address pins toward the memory
  typedef struct packed {
    logic chip_select_n;
    logic upper_lane_select_n;
    logic lower_lane_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic [ADDR_W-1:0] addr;
  } sbl_pins_t;

  localparam sbl_pins_t PINS_IDLE = '{
    chip_select_n: STROBE_IDLE,
    upper_lane_select_n: STROBE_IDLE,
    lower_lane_select_n: STROBE_IDLE,
    output_enable_n: STROBE_IDLE,
    write_enable_n: STROBE_IDLE,
    addr: '0
  };

  typedef enum {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_ACCESS,
    ST_RD_RELEASE,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_RET_ENTER,
    ST_RET_HOLD,
    ST_RET_RECOVER
  } sbl_state_t;

endpackage

// *** sbl_asserts.sv ***
// Checker for the byte-lane memory host controller strobes.
// Assumes it is bound into sbl_ctrl and sees only its ports.
`timescale 1ns/100ps
module sbl_asserts
  import sbl_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic req_valid, // Request present
  input wire logic req_ready, // Request taken
  input wire logic rsp_valid, // Access done
  input wire logic retain_active, // Retention level
  input wire sbl_pins_t pins, // Strobes and address
  input wire logic [DATA_W-1:0] dq_o, // Bus drive value
  input wire logic dq_oe // Bus drive enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Write pulse is two cycles low, then released
  sequence s_we_pulse;
    !pins.write_enable_n [*2] ##1 pins.write_enable_n;
  endsequence
  sequence s_busy;
    !req_ready [*2];
  endsequence
  property p_we_pulse;
    $fell(pins.write_enable_n) |-> s_we_pulse;
  endproperty
  property p_we_cs;
    !pins.write_enable_n |-> !pins.chip_select_n && dq_oe;
  endproperty
  property p_hold;
    !pins.write_enable_n || $rose(pins.write_enable_n) |-> $stable(dq_o);
  endproperty
  property p_rd_we;
    !pins.output_enable_n |-> pins.write_enable_n && !dq_oe;
  endproperty
  property p_addr;
    $fell(pins.chip_select_n) |-> $stable(pins.addr);
  endproperty
  property p_joint;
    $rose(pins.chip_select_n) |-> !$rose(pins.write_enable_n);
  endproperty
  property p_ret;
    retain_active |-> pins.chip_select_n && $past(pins.chip_select_n);
  endproperty
  property p_recover;
    $fell(retain_active) |-> pins.chip_select_n [*2];
  endproperty
  property p_resp;
    req_valid && req_ready |=> s_busy ##[1:6] rsp_valid;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("bad pulse");
  a_we_cs: assert property (p_we_cs) else $error("we w/o cs");
  a_hold: assert property (p_hold) else $error("data moved");
  a_rd_we: assert property (p_rd_we) else $error("we in read");
  a_addr: assert property (p_addr) else $error("addr late");
  a_joint: assert property (p_joint) else $error("joint rise");
  a_ret: assert property (p_ret) else $error("selected");
  a_recover: assert property (p_recover) else $error("early");
  a_resp: assert property (p_resp) else $error("no response");
endmodule

bind sbl_ctrl sbl_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .retain_active(retain_active), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe));

// *** sbl_sram_model.sv ***
// Behavioural 64K x 16 byte-lane static memory.
// Assumes the bench resolves the data wire from both drivers.
`timescale 1ns/100ps
module sbl_sram_model
  import sbl_pkg::*;
(
  input wire sbl_pins_t pins, // Strobes and address
  input wire logic [DATA_W-1:0] dq, // Resolved data wire
  output logic [DATA_W-1:0] dq_mem // Lane drive, junk when off
);
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] last = 16'h0000;
  logic sel, rd, rd_hi, rd_lo;
  // Reads only when selected, enabled and write enable high
  assign sel = !pins.chip_select_n;
  assign rd = sel && !pins.output_enable_n && pins.write_enable_n;
  assign rd_hi = rd && !pins.upper_lane_select_n;
  assign rd_lo = rd && !pins.lower_lane_select_n;
  // Released lanes show the inverse, never a stale value
  assign dq_mem = {rd_hi ? mem[pins.addr][15:8] : ~last[15:8],
    rd_lo ? mem[pins.addr][7:0] : ~last[7:0]};
  always @(rd_hi or rd_lo or pins.addr)
    if (rd_hi || rd_lo) last = mem[pins.addr];
  // Data is taken at the strobe rise that ends the overlap
  task automatic store();
    if (!pins.upper_lane_select_n) mem[pins.addr][15:8] = dq[15:8];
    if (!pins.lower_lane_select_n) mem[pins.addr][7:0] = dq[7:0];
  endtask
  always @(posedge pins.write_enable_n) if (sel) store();
  always @(posedge pins.chip_select_n) if (!pins.write_enable_n) store();
endmodule

// *** sbl_ctrl_test.sv ***
// Self-checking bench for the byte-lane memory host controller.
// Assumes the controller, its checker and the memory model are built.
`timescale 1ns/100ps
module sbl_ctrl_test
  import sbl_pkg::*;
();
  logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, retain_req = 1'b0;
  sbl_req_t req = '0;
  logic req_ready, rsp_valid, retain_active, dq_oe;
  logic [DATA_W-1:0] rsp_rdata, dq_o, dq_mem, dq_bus;
  sbl_pins_t pins;
  int failures = 0, checks_done = 0, n;
  logic [15:0] lfsr = 16'h9b1a;
  logic [15:0] a [8];
  logic [15:0] shadow [logic [15:0]];
  logic [16:0] exp_q [$];
  logic [16:0] e;
  assign dq_bus = dq_oe ? dq_o : dq_mem;
  sbl_ctrl dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .retain_req(retain_req),
    .retain_active(retain_active), .pins(pins), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_bus));
  sbl_sram_model mem (.pins(pins), .dq(dq_bus), .dq_mem(dq_mem));
  // 20 MHz clock
  initial forever #25 clk_sys = ~clk_sys;
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk_word(input logic [15:0] got, want);
    checks_done++;
    if (got !== want)
    begin
      failures++;
      $display("BAD %0t word %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_flag(input logic got, want);
    checks_done++;
    if (got !== want)
    begin
      failures++;
      $display("BAD %0t flag %b want %b", $time, got, want);
    end
  endtask
  // Request held until taken; the note is made at the taking edge
  task automatic access(input logic w, input logic [1:0] ln,
    input logic [15:0] ad, d);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    n = 0;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{write: w, lanes: ln, addr: ad, wdata: d};
    do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 40);
    if (w)
      shadow[ad] = (shadow.exists(ad) ? shadow[ad] & ~m : 16'h0)
        | (d & m);
    exp_q.push_back({!w, shadow[ad] & m});
  endtask
  task automatic idle();
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Each response takes the oldest note; a stray one counts as bad
  always @(posedge clk_sys)
    if (!rst && rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk_flag(1'b1, 1'b0);
      else
      begin
        e = exp_q.pop_front();
        if (e[16]) chk_word(rsp_rdata, e[15:0]);
      end
    end
  // Hang guard, well past the few hundred cycles needed
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    foreach (a[i]) a[i] = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : rnd();
    foreach (a[i]) access(1'b1, 2'b11, a[i], rnd());
    foreach (a[i]) access(1'b1, 2'(i), a[i], rnd());
    foreach (a[i]) for (int l = 1; l < 4; l++) access(1'b0, 2'(l), a[i], 16'h0);
    idle();
    retain_req = 1'b1;
    n = 0;
    while (retain_active !== 1'b1 && n++ < 20) @(posedge clk_sys);
    chk_flag(pins.chip_select_n, 1'b1);
    @(negedge clk_sys) req_valid = 1'b1;
    repeat (5) @(posedge clk_sys);
    chk_flag(req_ready, 1'b0);
    idle();
    retain_req = 1'b0;
    n = 0;
    while (retain_active !== 1'b0 && n++ < 20) @(posedge clk_sys);
    chk_flag(req_ready, 1'b0);
    chk_flag(pins.chip_select_n, 1'b1);
    access(1'b0, 2'b11, a[2], 16'h0);
    idle();
    repeat (20) @(posedge clk_sys);
    chk_flag(exp_q.size() == 0, 1'b1);
    end_sim();
  end
endmodule
